// file: spbm_partner.sv
// Far-side serial partner: async sender, async and clocked receiver
module spbm_partner (
  input  wire logic pclk,
  input  wire logic tx_line,
  input  wire logic sclk_line,
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_line = 1'b1;

  // Low start, data LSB first, optional ninth, high stop
  task automatic send_char(input logic [8:0] v, input int nb, input int dv, input int nin);
    rx_line <= 1'b0;
    repeat (dv) @(posedge pclk);
    for (int i = 0; i < nb + nin; i++) begin
      rx_line <= (i < nb) ? v[i] : v[8];
      repeat (dv) @(posedge pclk);
    end
    rx_line <= 1'b1;
    repeat (dv) @(posedge pclk);
  endtask

  task automatic hold_low(input int n);
    rx_line <= 1'b0;
    repeat (n) @(posedge pclk);
    rx_line <= 1'b1;
    repeat (40) @(posedge pclk);
  endtask

  // Result packs stop level, ninth bit and data
  task automatic get_char(input int nb, input int dv, input int nin, output logic [9:0] v);
    int n;
    n = 0;
    v = 10'h000;
    while (tx_line !== 1'b0 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    repeat (dv / 2) @(posedge pclk);
    for (int i = 0; i <= nb + nin; i++) begin
      repeat (dv) @(posedge pclk);
      if (i < nb)
        v[i] = tx_line;
      else if (i == nb + nin)
        v[9] = tx_line;
      else
        v[8] = tx_line;
    end
    repeat (dv) @(posedge pclk);
  endtask

  // Port drives the clock; data taken on its rising edge
  task automatic get_sync(output logic [7:0] v);
    int   i;
    int   n;
    logic prev;
    i = 0;
    n = 0;
    v = 8'h00;
    prev = sclk_line;
    while (i < 8 && n < 2000) begin
      @(posedge pclk);
      n++;
      if (sclk_line === 1'b1 && prev === 1'b0) begin
        v[i] = tx_line;
        i++;
      end
      prev = sclk_line;
    end
  endtask
endmodule

// file: spbm_pkg.sv
// Constants, register layout and carrier types of the serial-port block
package spbm_pkg;
  localparam int NPORT = 6;
  localparam int NEV   = 3;
  localparam int NEVT  = NPORT * NEV;

  localparam logic [7:0] PORT_STRIDE  = 8'h10;
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_EXT      = 8'h04;
  localparam logic [7:0] OFF_DATA     = 8'h08;
  localparam logic [7:0] OFF_STAT     = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h60;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h64;
  localparam logic [7:0] OFF_SYS      = 8'h68;
  localparam logic [7:0] OFF_BOOT     = 8'h6c;

  localparam int CTL_EN     = 0;
  localparam int CTL_SYNC   = 1;
  localparam int CTL_EXTCLK = 2;
  localparam int CTL_SEVEN  = 3;
  localparam int CTL_NINTH  = 4;
  localparam int CTL_IRDA   = 5;
  localparam int CTL_LANE   = 6;
  localparam int CTL_DIV    = 16;
  localparam int EXT_NOBRK  = 1;
  localparam int SYS_STMODE = 0;
  localparam int SYS_STGPO  = 2;
  localparam int SYS_GPOUT  = 3;
  localparam int SYS_GPOE   = 4;
  localparam int EV_RX      = 0;
  localparam int EV_TX      = 1;
  localparam int EV_BRK     = 2;

  localparam logic [15:0] MIN_DIV        = 16'h0008;
  localparam logic [31:0] CTRL_RST       = 32'h015b_0000;
  localparam logic [31:0] CTRL_CONV_RST  = 32'h0008_0003;
  localparam logic [31:0] PROGRAM_CABLE_CONNECTOR_CTRL      = 32'h015b_0001;
  localparam logic [31:0] EXT_RST        = 32'h0000_0000;
  localparam logic [4:0]  SYS_RST        = 5'h00;
  localparam logic [15:0] RUN_START_ADDR = 16'h0000;
  localparam logic [1:0]  BOOT_SETTLE    = 2'h3;
  localparam logic [3:0]  SYNC_BITS      = 4'h8;

  typedef enum logic [1:0] {ST_GPO, ST_FETCH, ST_INTACK, ST_HIGH} spbm_stmode_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} spbm_rx_t;

  typedef struct packed {
    logic rx;
    logic sclk;
  } spbm_pin_in_t;

  typedef struct packed {
    logic tx;
    logic sclk;
    logic sclk_oe;
  } spbm_pin_out_t;
endpackage

// file: spbm_serial_ports.sv
// Six serial ports with APB registers, startup-mode capture and status pin
//
// Behaviour
// - Async bit period never shorter than eight system clocks.
// - Seven or eight data bits per async character, chosen by control bit.
// - Optional ninth bit per character marks the first byte of a message.
// - Clocked mode shifts on a serial clock driven by port or partner.
// - Ports C and D clocked mode drive their clocks onto port D pins 2 and 0.
// - Ports E and F offer IrDA framing; nothing runs until configured.
// - E and F receive clock is taken from the lane carrying their transmit data.
// - Receiver flags a break when the input is held low.
// - Extended control bit 1 stops character assembly during a break.
// - Port A is the programming link in program mode, ordinary port in run mode.
// - Port A clock pin is general I/O while port A runs asynchronously.
// - On the converter variant port B is clocked; async use drops the converter link.
// - After reset, straps select cold boot or execution from address zero.
// - Straps sampled at reset: both high program mode, both low run mode.
// - Status pin: low on first opcode fetch, low on interrupt acknowledge, or output.
// - External reset restarts everything and straps are evaluated again.
//
// The APB slave port and the register offsets are this design's own decisions.
module spbm_serial_ports
  import spbm_pkg::*;
#(
  parameter bit HAS_CONVERTER = 1'b1
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           irq,
  input  wire spbm_pin_in_t [NPORT-1:0]  ser_in,
  output spbm_pin_out_t     [NPORT-1:0]  ser_out,
  output logic      [2:0]                port_e_tx_data,
  output logic      [2:0]                port_f_tx_data,
  input  wire logic [2:0]                port_e_rx_clock,
  input  wire logic [2:0]                port_f_rx_clock,
  output logic                           portd_pin2_o,
  output logic                           portd_pin2_oe,
  output logic                           portd_pin0_o,
  output logic                           portd_pin0_oe,
  input  wire logic                      startup_mode_pin0,
  input  wire logic                      startup_mode_pin1,
  input  wire logic                      fetch_first_cycle,
  input  wire logic                      int_ack_cycle,
  output logic                           status_out,
  output logic                           boot_done,
  output logic                           cold_boot,
  output logic                           run_start,
  output logic      [15:0]               start_addr,
  output logic                           converter_link_en
);

  function automatic logic hit(input logic [7:0] a, input int p, input logic [7:0] off);
    hit = a == 8'(8'(p * 16) + off);
  endfunction

  logic                        setup, wr, rd, any_hit, g_hit, irq_rd;
  logic [31:0]                 prdata_q, rdata_any, g_data;
  logic                        slverr_q, status_q, status_d;
  logic [NEVT-1:0]             irq_st_q, irq_mask_q, irq_clr, ev;
  logic [4:0]                  sys_q;
  logic [2:0]                  sm0_s, sm1_s;
  logic [1:0]                  settle_q;
  logic                        boot_done_q, program_cable_connector_q, run_q, straps_ok;
  logic [NPORT-1:0][31:0]      prd_p;
  logic [NPORT-1:0]            phit, sync_v, en_v, ckv_v;
  logic [1:0][2:0]             ef_tx, ef_ck;
  spbm_stmode_t                st_mode;

  // APB: data captured in setup, answer in the single access cycle
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = slverr_q & psel & penable;

  assign g_hit = paddr == OFF_IRQ_STAT || paddr == OFF_IRQ_MASK ||
                 paddr == OFF_SYS || paddr == OFF_BOOT;
  assign g_data = paddr == OFF_IRQ_STAT ? 32'(irq_st_q) :
                  paddr == OFF_IRQ_MASK ? 32'(irq_mask_q) :
                  paddr == OFF_SYS      ? 32'(sys_q) :
                  paddr == OFF_BOOT     ? {28'h0, ckv_v[0], run_q, program_cable_connector_q, boot_done_q} :
                  32'h0;

  always_comb begin
    rdata_any = g_hit ? g_data : 32'h0;
    any_hit   = g_hit;
    for (int p = 0; p < NPORT; p++) begin
      rdata_any = rdata_any | prd_p[p];
      any_hit   = any_hit | phit[p];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0 : rdata_any;
      slverr_q <= ~any_hit;
    end
  end

  // Only bits seen by the read are cleared; a new event wins
  assign irq_rd  = rd && paddr == OFF_IRQ_STAT;
  assign irq_clr = irq_rd ? prdata_q[NEVT-1:0] : '0;
  assign irq     = |(irq_st_q & irq_mask_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q   <= '0;
      irq_mask_q <= '0;
      sys_q      <= SYS_RST;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | ev;
      if (wr && paddr == OFF_IRQ_MASK) irq_mask_q <= pwdata[NEVT-1:0];
      if (wr && paddr == OFF_SYS) sys_q <= pwdata[4:0];
    end
  end

  // Strap capture after reset release, once synchronisers settle
  assign straps_ok = (sm0_s[1] == sm0_s[2]) && (sm1_s[1] == sm1_s[2]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sm0_s       <= 3'h0;
      sm1_s       <= 3'h0;
      settle_q    <= 2'h0;
      boot_done_q <= 1'b0;
      program_cable_connector_q      <= 1'b0;
      run_q       <= 1'b0;
    end else begin
      sm0_s <= {sm0_s[1:0], startup_mode_pin0};
      sm1_s <= {sm1_s[1:0], startup_mode_pin1};
      if (!boot_done_q) begin
        if (settle_q != BOOT_SETTLE) begin
          settle_q <= settle_q + 2'h1;
        end else if (straps_ok) begin
          boot_done_q <= 1'b1;
          program_cable_connector_q      <= sm0_s[2] & sm1_s[2];
          run_q       <= ~sm0_s[2] & ~sm1_s[2];
        end
      end
    end
  end

  assign boot_done  = boot_done_q;
  assign cold_boot  = boot_done_q & program_cable_connector_q;
  assign run_start  = boot_done_q & run_q;
  assign start_addr = RUN_START_ADDR;

  // Status pin
  assign st_mode = spbm_stmode_t'(sys_q[SYS_STMODE +: 2]);

  always_comb begin
    case (st_mode)
      ST_GPO:    status_d = sys_q[SYS_STGPO];
      ST_FETCH:  status_d = ~fetch_first_cycle;
      ST_INTACK: status_d = ~int_ack_cycle;
      default:   status_d = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_q <= 1'b1;
    else status_q <= status_d;
  end

  assign status_out = status_q;

  assign ef_ck          = {port_f_rx_clock, port_e_rx_clock};
  assign port_e_tx_data = ef_tx[0];
  assign port_f_tx_data = ef_tx[1];

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    localparam bit EF     = p >= 4;
    localparam bit CLK_OK = p < 4;
    localparam logic [31:0] RST = (p == 1 && HAS_CONVERTER) ? CTRL_CONV_RST : CTRL_RST;

    logic [31:0] ctrl_q, ext_q, ctl;
    logic [2:0]  rx_s, ck_s;
    logic        rxv_q, ckv_q, rxp_q, ckp_q, tx_q;
    logic [15:0] div, half, bcnt_q, rcnt_q;
    logic [10:0] sh_q, frame;
    logic [3:0]  bit_q, ridx_q, nbits, rlast, tx_len;
    logic [8:0]  rsh_q, rdat_q, a_word, rx_word;
    logic        busy_q, rfull_q, ovr_q, brk_q;
    logic        en, sync_m, ext_m, irda_m, seven, nin, nobrk;
    logic        rise, fall, rx_fall, tick, samp, tx_done, start_tx;
    logic        rx_start, rs_tick, stop_ev, brk_det, store, txb, sck, sck_oe;
    logic        wr_c, wr_e, wr_d, rd_d, rd_s, ck_pin;
    logic [1:0]  lane;
    spbm_rx_t    rst_q;

    assign ctl    = (p == 0 && program_cable_connector_q) ? PROGRAM_CABLE_CONNECTOR_CTRL : ctrl_q;
    assign en     = ctl[CTL_EN];
    assign sync_m = CLK_OK && ctl[CTL_SYNC];
    assign ext_m  = sync_m && ctl[CTL_EXTCLK];
    assign irda_m = EF && ctl[CTL_IRDA];
    assign seven  = ctl[CTL_SEVEN] & ~sync_m;
    assign nin    = ctl[CTL_NINTH] & ~sync_m;
    assign nobrk  = ext_q[EXT_NOBRK];
    assign div    = ctl[CTL_DIV +: 16] < MIN_DIV ? MIN_DIV : ctl[CTL_DIV +: 16];
    assign half   = {1'b0, div[15:1]};
    assign lane   = ctl[CTL_LANE +: 2] == 2'h3 ? 2'h0 : ctl[CTL_LANE +: 2];
    assign nbits  = seven ? 4'h7 : 4'h8;

    if (EF) begin : g_ef
      assign ck_pin = ef_ck[p-4][lane];
      for (genvar l = 0; l < 3; l++) begin : g_lane
        assign ef_tx[p-4][l] = (lane == 2'(l)) ? tx_q : 1'b1;
      end
    end else begin : g_ck
      assign ck_pin = ser_in[p].sclk;
    end

    // Pin synchronisers: a change counts when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_s  <= 3'h7;
        ck_s  <= 3'h7;
        rxv_q <= 1'b1;
        ckv_q <= 1'b1;
        rxp_q <= 1'b1;
        ckp_q <= 1'b1;
      end else begin
        rx_s  <= {rx_s[1:0], ser_in[p].rx};
        ck_s  <= {ck_s[1:0], ck_pin};
        rxv_q <= (rx_s[1] == rx_s[2]) ? rx_s[2] : rxv_q;
        ckv_q <= (ck_s[1] == ck_s[2]) ? ck_s[2] : ckv_q;
        rxp_q <= rxv_q;
        ckp_q <= ckv_q;
      end
    end

    assign rise    = ckv_q & ~ckp_q;
    assign fall    = ~ckv_q & ckp_q;
    assign rx_fall = rxp_q & ~rxv_q;

    assign wr_c = wr && hit(paddr, p, OFF_CTRL);
    assign wr_e = wr && hit(paddr, p, OFF_EXT);
    assign wr_d = wr && hit(paddr, p, OFF_DATA);
    assign rd_d = rd && hit(paddr, p, OFF_DATA);
    assign rd_s = rd && hit(paddr, p, OFF_STAT);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl_q <= RST;
        ext_q  <= EXT_RST;
      end else begin
        if (wr_c) ctrl_q <= pwdata;
        if (wr_e) ext_q <= pwdata;
      end
    end

    // Transmit frame, LSB first, padded with stop-level ones
    assign frame = sync_m ? {3'h7, pwdata[7:0]} :
                   seven  ? (nin ? {2'h3, pwdata[8], pwdata[6:0], 1'b0}
                                 : {3'h7, pwdata[6:0], 1'b0})
                          : (nin ? {1'b1, pwdata[8:0], 1'b0}
                                 : {2'h3, pwdata[7:0], 1'b0});
    assign tx_len   = sync_m ? SYNC_BITS : 4'(nbits + {3'h0, nin} + 4'h2);
    assign tick     = ext_m ? fall : (bcnt_q == 16'(div - 16'h1));
    assign samp     = busy_q && sync_m && (ext_m ? rise : bcnt_q == half);
    assign tx_done  = busy_q && tick && bit_q == 4'h1;
    assign start_tx = wr_d && en && !busy_q;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        busy_q <= 1'b0;
        sh_q   <= 11'h7ff;
        bit_q  <= 4'h0;
        bcnt_q <= 16'h0;
      end else if (start_tx) begin
        busy_q <= 1'b1;
        sh_q   <= frame;
        bit_q  <= tx_len;
        bcnt_q <= 16'h0;
      end else if (busy_q) begin
        bcnt_q <= (bcnt_q == 16'(div - 16'h1)) ? 16'h0 : 16'(bcnt_q + 16'h1);
        if (tick) begin
          sh_q   <= {1'b1, sh_q[10:1]};
          bit_q  <= bit_q - 4'h1;
          busy_q <= bit_q != 4'h1;
        end
      end
    end

    // Async receiver
    assign rx_start = en && !sync_m && rx_fall && !(nobrk && brk_q);
    assign rlast    = 4'(nbits + {3'h0, nin});
    assign rs_tick  = rcnt_q == 16'(div - 16'h1);
    assign stop_ev  = rst_q == RX_BITS && rs_tick && ridx_q == rlast;
    assign brk_det  = stop_ev && !rxv_q && rsh_q == 9'h0;
    assign a_word   = seven ? {nin & rsh_q[7], 1'b0, rsh_q[6:0]} : {nin & rsh_q[8], rsh_q[7:0]};
    assign rx_word  = sync_m ? {1'b0, rsh_q[8:1]} : a_word;
    assign store    = (stop_ev && !(brk_det && nobrk)) || (sync_m && tx_done);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rst_q  <= RX_IDLE;
        rcnt_q <= 16'h0;
        ridx_q <= 4'h0;
        rsh_q  <= 9'h0;
      end else begin
        if (samp) rsh_q <= {rxv_q, rsh_q[8:1]};
        case (rst_q)
          RX_IDLE: if (rx_start) begin
            rst_q  <= RX_START;
            rcnt_q <= 16'h0;
            ridx_q <= 4'h0;
            rsh_q  <= 9'h0;
          end
          RX_START: if (rcnt_q == half) begin
            rcnt_q <= 16'h0;
            rst_q  <= rxv_q ? RX_IDLE : RX_BITS;
          end else begin
            rcnt_q <= 16'(rcnt_q + 16'h1);
          end
          RX_BITS: if (rs_tick) begin
            rcnt_q <= 16'h0;
            if (ridx_q == rlast) begin
              rst_q <= RX_IDLE;
            end else begin
              rsh_q[ridx_q] <= rxv_q;
              ridx_q        <= ridx_q + 4'h1;
            end
          end else begin
            rcnt_q <= 16'(rcnt_q + 16'h1);
          end
          default: rst_q <= RX_IDLE;
        endcase
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rdat_q  <= 9'h0;
        rfull_q <= 1'b0;
        ovr_q   <= 1'b0;
        brk_q   <= 1'b0;
        tx_q    <= 1'b1;
      end else begin
        if (store) rdat_q <= rx_word;
        rfull_q <= store | (rfull_q & ~rd_d);
        ovr_q   <= (store & rfull_q & ~rd_d) | (ovr_q & ~rd_s);
        brk_q   <= brk_det | (brk_q & ~rxv_q);
        tx_q    <= txb;
      end
    end

    // IrDA sends a quarter-bit high pulse per zero bit, idles low
    assign txb = irda_m ? (busy_q && !sh_q[0] && bcnt_q < {2'h0, div[15:2]})
                        : (busy_q ? sh_q[0] : 1'b1);
    assign sck    = (p == 0 && !sync_m) ? sys_q[SYS_GPOUT] :
                    (busy_q && !ext_m) ? (bcnt_q >= half) : 1'b1;
    assign sck_oe = (p == 0 && !sync_m) ? sys_q[SYS_GPOE] : (en && sync_m && !ext_m);

    assign ser_out[p] = {tx_q, sck, sck_oe};
    assign ev[p*NEV + EV_RX]  = store;
    assign ev[p*NEV + EV_TX]  = tx_done;
    assign ev[p*NEV + EV_BRK] = brk_det;
    assign sync_v[p] = sync_m;
    assign en_v[p]   = en;
    assign ckv_v[p]  = ckv_q;
    assign phit[p]   = hit(paddr, p, OFF_CTRL) || hit(paddr, p, OFF_EXT) ||
                       hit(paddr, p, OFF_DATA) || hit(paddr, p, OFF_STAT);
    assign prd_p[p]  = hit(paddr, p, OFF_CTRL) ? ctrl_q :
                       hit(paddr, p, OFF_EXT)  ? ext_q :
                       hit(paddr, p, OFF_DATA) ? {23'h0, rdat_q} :
                       hit(paddr, p, OFF_STAT) ? {27'h0, rxv_q, ovr_q, brk_q, rfull_q, busy_q} :
                       32'h0;
  end

  assign portd_pin2_o      = ser_out[2].sclk;
  assign portd_pin2_oe     = ser_out[2].sclk_oe;
  assign portd_pin0_o      = ser_out[3].sclk;
  assign portd_pin0_oe     = ser_out[3].sclk_oe;
  assign converter_link_en = HAS_CONVERTER && sync_v[1] && en_v[1];

endmodule

// file: spbm_serial_ports_chk.sv
// Port-level checker for the serial-port block
module spbm_chk
  import spbm_pkg::*;
#(
  parameter bit HAS_CONVERTER = 1'b1
) (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic [31:0]               prdata,
  input wire logic                      irq,
  input wire spbm_pin_out_t [NPORT-1:0] ser_out,
  input wire logic [2:0]                port_e_tx_data,
  input wire logic [2:0]                port_f_tx_data,
  input wire logic                      portd_pin2_o,
  input wire logic                      portd_pin2_oe,
  input wire logic                      portd_pin0_o,
  input wire logic                      portd_pin0_oe,
  input wire logic                      boot_done,
  input wire logic                      cold_boot,
  input wire logic                      run_start,
  input wire logic [15:0]               start_addr,
  input wire logic                      converter_link_en
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_apb_ready: assert property (psel && penable |-> pready)
    else $error("pready low in access cycle");
  chk_slverr_phase: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access cycle");
  chk_rdata_hold: assert property (psel && penable |=> $stable(prdata))
    else $error("read data changed after access");
  chk_pin2_copy: assert property (portd_pin2_o == ser_out[2].sclk &&
    portd_pin2_oe == ser_out[2].sclk_oe) else $error("port C clock not on pin 2");
  chk_pin0_copy: assert property (portd_pin0_o == ser_out[3].sclk &&
    portd_pin0_oe == ser_out[3].sclk_oe) else $error("port D clock not on pin 0");
  chk_lane_idle: assert property ($countones(port_e_tx_data) >= 2 &&
    $countones(port_f_tx_data) >= 2) else $error("unselected lane not idle");
  chk_boot_excl: assert property (!(cold_boot && run_start))
    else $error("both startup modes active");
  chk_boot_gate: assert property (cold_boot || run_start |-> boot_done)
    else $error("mode active before straps captured");
  chk_start_addr: assert property (run_start |-> start_addr == RUN_START_ADDR)
    else $error("run start address wrong");
  chk_boot_settle: assert property ($rose(presetn) |-> ##[1:10] boot_done)
    else $error("straps not captured after reset");
  chk_conv_reset: assert property ($rose(presetn) |-> converter_link_en == HAS_CONVERTER)
    else $error("converter link wrong after reset");

  cov_cold_boot: cover property (cold_boot);
  cov_irq: cover property ($rose(irq));
  cov_slverr: cover property (pslverr);
  cov_pin2: cover property (portd_pin2_oe);
endmodule

bind spbm_serial_ports spbm_chk #(.HAS_CONVERTER(HAS_CONVERTER)) u_chk (.*);

// file: testbench.sv
// Self-checking bench for the serial-port block
module testbench
  import spbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] ST_TBL [7] = '{6'h18, 6'h15, 6'h24, 6'h29, 6'h3d, 6'h03, 6'h00};

  logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]                paddr;
  logic [31:0]               pwdata, prdata;
  spbm_pin_in_t  [NPORT-1:0] ser_in;
  spbm_pin_out_t [NPORT-1:0] ser_out;
  logic [2:0]                port_e_tx_data, port_f_tx_data, port_e_rx_clock, port_f_rx_clock;
  logic                      portd_pin2_o, portd_pin2_oe, portd_pin0_o, portd_pin0_oe;
  logic                      startup_mode_pin0, startup_mode_pin1;
  logic                      fetch_first_cycle, int_ack_cycle, status_out, boot_done;
  logic                      cold_boot, run_start, converter_link_en;
  logic [15:0]               start_addr;
  logic                      prt_rx, mon_tx, mon_sclk, slv_q;
  int                        rx_sel, tx_sel, miscompares, tests_run;

  spbm_serial_ports dut (.*);
  spbm_partner prt (.pclk, .tx_line(mon_tx), .sclk_line(mon_sclk), .rx_line(prt_rx));

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      ser_in[p].rx = (p == rx_sel) ? prt_rx : 1'b1;
      ser_in[p].sclk = ser_out[p].sclk_oe ? ser_out[p].sclk : 1'b1;
    end
    mon_tx = (tx_sel == 4) ? port_e_tx_data[2] : ser_out[tx_sel].tx;
    mon_sclk = ser_out[tx_sel].sclk;
  end

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic complete_run;
    $display("Comparisons %0d, miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) begin
      miscompares++;
      complete_run();
    end
    rd = prdata;
    slv_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    apb(1'b0, a, 32'h0, d);
    check(d & m, e);
  endtask

  // Straps held by the cable through reset
  task automatic do_reset(input logic strap);
    int n;
    n = 0;
    presetn <= 1'b0;
    startup_mode_pin0 <= strap;
    startup_mode_pin1 <= strap;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    while (boot_done !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    check(32'(boot_done), 32'h1);
  endtask

  task automatic t_reset_state;
    rdchk(8'h10, 32'hffff_ffff, CTRL_CONV_RST);
    rdchk(8'h20, 32'hffff_ffff, CTRL_RST);
    rdchk(OFF_BOOT, 32'h7, 32'h5);
    check(32'({run_start, cold_boot, converter_link_en}), 32'h5);
    rdchk(8'h70, 32'hffff_ffff, 32'h0);
    check(32'(slv_q), 32'h1);
  endtask

  task automatic tx_case(input logic [31:0] c, input logic [31:0] d, input int nb,
                         input int nin, input logic [9:0] e);
    logic [9:0] v;
    tx_sel <= 0;
    wr(8'h00, c);
    wr(OFF_DATA, d);
    prt.get_char(nb, 8, nin, v);
    check(32'(v), 32'(e));
  endtask

  task automatic t_rx_irq;
    int n;
    n = 0;
    wr(8'h20, 32'h0008_0001);
    wr(OFF_IRQ_MASK, 32'h40);
    rx_sel <= 2;
    prt.send_char(9'h03c, 8, 8, 0);
    while (irq !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check(32'(irq), 32'h1);
    rdchk(8'h2c, 32'h2, 32'h2);
    rdchk(8'h28, 32'h1ff, 32'h03c);
    rdchk(OFF_IRQ_STAT, 32'h40, 32'h40);
    check(32'(irq), 32'h0);
    rdchk(OFF_IRQ_STAT, 32'h40, 32'h0);
  endtask

  task automatic t_break;
    for (int e = 0; e < 2; e++) begin
      wr(8'h30, 32'h0008_0001);
      wr(8'h34, 32'(e) << EXT_NOBRK);
      rx_sel <= 3;
      prt.hold_low(120);
      rdchk(8'h3c, 32'h2, e ? 32'h0 : 32'h2);
      rdchk(8'h38, 32'h1ff, 32'h0);
      rdchk(OFF_IRQ_STAT, 32'ha00, e ? 32'h800 : 32'ha00);
    end
  endtask

  task automatic t_clocked;
    logic [7:0] v;
    wr(8'h20, 32'h0008_0003);
    wr(8'h30, 32'h0008_0003);
    check(32'({portd_pin2_oe, portd_pin0_oe}), 32'h3);
    tx_sel <= 2;
    wr(8'h28, 32'h096);
    prt.get_sync(v);
    check(32'(v), 32'h96);
  endtask

  task automatic t_lane;
    logic [9:0] v;
    wr(8'h48, 32'h055);
    rdchk(8'h4c, 32'h1, 32'h0);
    check(32'(port_e_tx_data), 32'h7);
    wr(8'h40, 32'h0008_0081);
    tx_sel <= 4;
    wr(8'h48, 32'h0c3);
    prt.get_char(8, 8, 0, v);
    check(32'(v), 32'h2c3);
    wr(8'h40, 32'h0008_00a1);
    @(posedge pclk);
    check(32'(port_e_tx_data), 32'h3);
  endtask

  task automatic t_status;
    foreach (ST_TBL[i]) begin
      wr(OFF_SYS, 32'({ST_TBL[i][1], ST_TBL[i][5:4]}));
      fetch_first_cycle <= ST_TBL[i][3];
      int_ack_cycle <= ST_TBL[i][2];
      @(posedge pclk);
      fetch_first_cycle <= 1'b0;
      int_ack_cycle <= 1'b0;
      @(posedge pclk);
      check(32'(status_out), 32'(ST_TBL[i][0]));
    end
  endtask

  task automatic t_gpio;
    wr(OFF_SYS, 32'h18);
    check(32'({ser_out[0].sclk, ser_out[0].sclk_oe}), 32'h3);
    wr(OFF_SYS, 32'h10);
    check(32'({ser_out[0].sclk, ser_out[0].sclk_oe}), 32'h1);
    repeat (4) @(posedge pclk);
    rdchk(OFF_BOOT, 32'h8, 32'h0);
  endtask

  task automatic t_program;
    logic [9:0] v;
    rdchk(OFF_BOOT, 32'h7, 32'h3);
    check(32'({cold_boot, run_start}), 32'h2);
    tx_sel <= 0;
    wr(OFF_DATA, 32'h05a);
    prt.get_char(8, 347, 0, v);
    check(32'(v), 32'h25a);
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    complete_run();
  end

  initial begin
    {presetn, psel, penable, pwrite, fetch_first_cycle, int_ack_cycle} = '0;
    {startup_mode_pin0, startup_mode_pin1, paddr, pwdata} = '0;
    {port_e_rx_clock, port_f_rx_clock} = 6'h3f;
    {rx_sel, tx_sel, miscompares, tests_run} = '0;
    do_reset(1'b0);
    t_reset_state();
    tx_case(32'h0004_0001, 32'h0a5, 8, 0, 10'h2a5);
    tx_case(32'h0008_0011, 32'h1a5, 8, 1, 10'h3a5);
    tx_case(32'h0008_0019, 32'h0aa, 7, 1, 10'h22a);
    t_rx_irq();
    t_break();
    t_clocked();
    t_lane();
    t_status();
    t_gpio();
    do_reset(1'b1);
    t_program();
    complete_run();
  end
endmodule
